// [logic/mmrwf_pkg.sv]
// Constants, types and register map for the bus-side read and write FIFO pair
//------------------------------------------------------------
// Contract
// - While hold is set, no bus read takes a word from the read FIFO, and samples keep filling it.
// - When the read FIFO is full, sample_ready drops so that no sample is lost.
// - sample_ready is high only when the read FIFO can take a new sample.
// - bus_side_read_qualifier is high exactly when the bus read word carries a real FIFO word.
// - Each FIFO depth is a parameter that must be greater than 2.
// - The word format is signed integer, signed fractional or unsigned integer.
// - The fraction bit count counts only in the signed fractional format.
// - A bus-written word appears on downstream_word_out one cycle after downstream_ready.
// - While hold is set, written words are kept, then released in order one per clock.
// - downstream_word_out carries the oldest written word not yet delivered.
// - downstream_valid is high exactly when downstream_word_out holds a real word.
//------------------------------------------------------------
package mmrwf_pkg;

   typedef enum logic [1:0] {
      MMRWF_SIGNED_INT  = 2'h0,
      MMRWF_SIGNED_FRAC = 2'h1,
      MMRWF_UNSIGNED    = 2'h2
   } mmrwf_fmt_e;

   // Register bus
   localparam int         ADDR_W        = 4;
   localparam int         DATA_W        = 32;
   localparam logic [3:0] REG_RD_DATA   = 4'h0;
   localparam logic [3:0] REG_WR_DATA   = 4'h4;
   localparam logic [3:0] REG_STATUS    = 4'h8;
   localparam logic [3:0] REG_CTRL      = 4'hc;
   localparam int         CTRL_HOLD_BIT = 0;
   localparam logic       CTRL_RESET    = 1'h0;

   // Status fields
   localparam int ST_RD_EMPTY = 0;
   localparam int ST_RD_FULL  = 1;
   localparam int ST_WR_EMPTY = 2;
   localparam int ST_WR_FULL  = 3;
   localparam int ST_HOLD     = 4;
   localparam int ST_RD_COUNT = 8;
   localparam int ST_WR_COUNT = 16;

   // Queue and word format
   localparam int         FIFO_DEPTH = 8;
   localparam int         CNT_W      = $clog2(FIFO_DEPTH + 1);
   localparam mmrwf_fmt_e DATA_FMT   = MMRWF_SIGNED_FRAC;
   localparam int         INT_BITS   = 8;
   localparam int         FRAC_BITS  = 8;
   localparam logic       SINGLE_BIT = 1'h0;
   localparam int         WORD_W     = SINGLE_BIT ? 1 :
                                       (DATA_FMT == MMRWF_SIGNED_FRAC) ? INT_BITS + FRAC_BITS :
                                       INT_BITS;
   localparam logic       FMT_SIGNED = (DATA_FMT != MMRWF_UNSIGNED) && !SINGLE_BIT;

endpackage : mmrwf_pkg

// [logic/mmrwf_top.sv]
// Bus-side read FIFO and write FIFO with a shared register port
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps

//------------------------------------------------------------
// Queue of flip-flops
//------------------------------------------------------------
module mmrwf_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 8,
   parameter int CW    = 4
) (
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          in_valid,
   output wire logic          in_ready,
   input  wire logic [W-1:0]  in_data,
   output wire logic          out_valid,
   input  wire logic          out_ready,
   output wire logic [W-1:0]  out_data,
   output logic      [CW-1:0] count
);
   localparam int PW = $clog2(DEPTH);

   logic [W-1:0]  mem [DEPTH];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;

   wire       push  = in_valid && in_ready;
   wire       pop   = out_valid && out_ready;
   wire [PW-1:0] wr_ptr_inc = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
   wire [PW-1:0] rd_ptr_inc = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;

   assign in_ready  = (count != CW'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) wr_ptr <= wr_ptr_inc;
         if (pop) rd_ptr <= rd_ptr_inc;
         count <= count + CW'(push) - CW'(pop);
      end
   end

   depth_min_a: assert property (@(posedge clk) DEPTH > 2)
      else $error("fifo depth must exceed two");
endmodule : mmrwf_fifo

//------------------------------------------------------------
// Top
//------------------------------------------------------------
module mmrwf_top import mmrwf_pkg::*; (
   input  wire logic              clk,
   input  wire logic              rst,
   // Register port
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] bus_side_write_word,
   input  wire logic              wr_stb,
   input  wire logic              rd_stb,
   output logic      [DATA_W-1:0] bus_side_read_word,
   output logic                   bus_side_read_qualifier,
   // Sample side of the read FIFO
   input  wire logic [WORD_W-1:0] sample_in,
   input  wire logic              sample_qualifier,
   output wire logic              sample_ready,
   // Downstream side of the write FIFO
   input  wire logic              downstream_ready,
   output logic      [WORD_W-1:0] downstream_word_out,
   output logic                   downstream_valid
);

   //------------------------------------------------------------
   // Decode
   //------------------------------------------------------------
   logic              hold;
   wire               rd_data_sel = rd_stb && (addr == REG_RD_DATA);
   wire               wr_data_sel = wr_stb && (addr == REG_WR_DATA);
   wire               ctrl_wr     = wr_stb && (addr == REG_CTRL);

   wire               rd_out_valid;
   wire [WORD_W-1:0]  rd_head;
   wire [CNT_W-1:0]   rd_count;
   wire               rd_pop = rd_data_sel && !hold && rd_out_valid;

   wire               wr_in_ready;
   wire               wr_out_valid;
   wire [WORD_W-1:0]  wr_head;
   wire [CNT_W-1:0]   wr_count;
   // Output stage refills only on a ready cycle, giving the one-cycle delay
   wire               wr_pop = downstream_ready && !hold && wr_out_valid;

   //------------------------------------------------------------
   // Queues
   //------------------------------------------------------------
   // Samples are on this clock already, so no synchroniser
   mmrwf_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH), .CW(CNT_W)) u_rd_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (sample_qualifier),
      .in_ready  (sample_ready),
      .in_data   (sample_in),
      .out_valid (rd_out_valid),
      .out_ready (rd_pop),
      .out_data  (rd_head),
      .count     (rd_count)
   );

   // A write into a full queue is dropped; software checks status first
   mmrwf_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH), .CW(CNT_W)) u_wr_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (wr_data_sel),
      .in_ready  (wr_in_ready),
      .in_data   (bus_side_write_word[WORD_W-1:0]),
      .out_valid (wr_out_valid),
      .out_ready (wr_pop),
      .out_data  (wr_head),
      .count     (wr_count)
   );

   //------------------------------------------------------------
   // Read data formatting
   //------------------------------------------------------------
   // Signed formats extend the sign bit so software sees a plain int
   wire               sign_fill   = FMT_SIGNED && rd_head[WORD_W-1];
   wire [DATA_W-1:0]  rd_word_ext = {{(DATA_W - WORD_W){sign_fill}}, rd_head};
   wire [DATA_W-1:0]  status_word = {{(DATA_W - ST_WR_COUNT - CNT_W){1'b0}}, wr_count,
                                     {(ST_WR_COUNT - ST_RD_COUNT - CNT_W){1'b0}}, rd_count,
                                     {(ST_RD_COUNT - ST_HOLD - 1){1'b0}}, hold,
                                     !wr_in_ready, !wr_out_valid,
                                     !sample_ready, !rd_out_valid};
   wire [DATA_W-1:0]  ctrl_word   = {{(DATA_W - 1){1'b0}}, hold};

   wire [DATA_W-1:0]  next_read_word =
      (rd_pop)                                 ? rd_word_ext :
      (rd_stb && addr == REG_STATUS)           ? status_word :
      (rd_stb && addr == REG_CTRL)             ? ctrl_word   :
                                                 '0;

   //------------------------------------------------------------
   // Registers
   //------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         hold <= CTRL_RESET;
      end else if (ctrl_wr) begin
         hold <= bus_side_write_word[CTRL_HOLD_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         bus_side_read_word      <= '0;
         bus_side_read_qualifier <= 1'b0;
      end else begin
         bus_side_read_word      <= next_read_word;
         bus_side_read_qualifier <= rd_pop;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         downstream_word_out <= '0;
         downstream_valid    <= 1'b0;
      end else begin
         if (wr_pop) downstream_word_out <= wr_head;
         downstream_valid <= wr_pop;
      end
   end

   //------------------------------------------------------------
   // Assertions
   //------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   rd_hold_block_a: assert property (rd_data_sel && hold |=> !bus_side_read_qualifier)
      else $error("read fifo released a word during hold");
   rd_hold_fill_a: assert property (hold && sample_qualifier && sample_ready
                                    && !rd_data_sel |=> rd_count == $past(rd_count) + 1'b1)
      else $error("read fifo did not fill during hold");
   rd_full_ready_a: assert property (rd_count == CNT_W'(FIFO_DEPTH) |-> !sample_ready)
      else $error("ready high while read fifo full");
   rd_ready_room_a: assert property (!sample_ready |-> rd_count == CNT_W'(FIFO_DEPTH))
      else $error("ready low while read fifo has room");
   rd_qual_match_a: assert property (##1 bus_side_read_qualifier ==
                                     $past(rd_data_sel && !hold && rd_count != '0))
      else $error("read qualifier does not match a real word");
   rd_order_a: assert property (rd_pop |=> bus_side_read_word[WORD_W-1:0] == $past(rd_head))
      else $error("read word is not the fifo head");
   rd_sign_ext_a: assert property (bus_side_read_qualifier && FMT_SIGNED |->
                                   bus_side_read_word[DATA_W-1] ==
                                   bus_side_read_word[WORD_W-1])
      else $error("signed read word not sign extended");
   wr_latency_a: assert property (downstream_ready && !hold && wr_count != '0
                                  |=> downstream_valid)
      else $error("downstream word late after ready");
   wr_hold_a: assert property (hold |=> !downstream_valid)
      else $error("write fifo released a word during hold");
   wr_rate_a: assert property (!hold && downstream_ready && wr_count > 2'd1 ##1
                               downstream_ready && !hold |-> downstream_valid [*2])
      else $error("write fifo not releasing one word per clock");
   wr_oldest_a: assert property (downstream_valid |-> downstream_word_out == $past(wr_head))
      else $error("downstream word is not the oldest");
   wr_valid_only_a: assert property (downstream_valid |->
                                     $past(downstream_ready) && $past(wr_count) != '0)
      else $error("downstream valid without a real word");

   rd_fill_full_c: cover property (hold ##1 !sample_ready);
   rd_read_c:      cover property (rd_pop ##1 bus_side_read_qualifier);
   wr_burst_c:     cover property (hold ##1 !hold ##1 downstream_valid [*3]);
   wr_full_c:      cover property (!wr_in_ready && wr_data_sel);

endmodule : mmrwf_top

// [dv/mmrwf_user_model.sv]
// Sample source and downstream sink standing beside the FIFO pair
`timescale 1ns/1ps

module mmrwf_user_model import mmrwf_pkg::*; (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic [7:0]        src_total,
   input  wire logic              sink_en,
   input  wire logic              sample_ready,
   output logic      [WORD_W-1:0] sample_in,
   output logic                   sample_qualifier,
   output logic                   downstream_ready
);
   logic [7:0]        sent;
   logic [WORD_W-1:0] last;

   // Idle data is the inverse of the last word so a stale value never looks real
   assign sample_qualifier = (sent < src_total);
   assign sample_in        = sample_qualifier ? WORD_W'(16'h8a00 + sent) : ~last;
   assign downstream_ready = sink_en;

   always_ff @(posedge clk) begin
      if (rst) begin
         sent <= 8'h0;
         last <= '0;
      end else if (sample_qualifier && sample_ready) begin
         sent <= sent + 8'h1;
         last <= sample_in;
      end
   end
endmodule : mmrwf_user_model

// [dv/tb_mmrwf_top.sv]
// Self-checking testbench for the bus-side read and write FIFO pair
`timescale 1ns/1ps

module tb_mmrwf_top import mmrwf_pkg::*;;
   logic              clk = 1'b0;
   logic              rst = 1'b1;
   logic              wr_stb = 1'b0;
   logic              rd_stb = 1'b0;
   logic              sink_en = 1'b0;
   logic [ADDR_W-1:0] addr = 4'h0;
   logic [DATA_W-1:0] wdata = 32'h0;
   logic [DATA_W-1:0] rdata;
   logic              rq, sample_ready, sample_qualifier, downstream_ready, downstream_valid;
   logic [WORD_W-1:0] sample_in, downstream_word_out;
   logic [7:0]        src_total = 8'h0;
   int                miscompares = 0;
   int                cmp_count = 0;

   always #12.5 clk = ~clk;

   mmrwf_top mmrwf_top_i (.clk(clk), .rst(rst), .addr(addr), .bus_side_write_word(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .bus_side_read_word(rdata),
      .bus_side_read_qualifier(rq), .sample_in(sample_in), .sample_qualifier(sample_qualifier),
      .sample_ready(sample_ready), .downstream_ready(downstream_ready),
      .downstream_word_out(downstream_word_out), .downstream_valid(downstream_valid));

   mmrwf_user_model mmrwf_user_model_i (.clk(clk), .rst(rst), .src_total(src_total),
      .sink_en(sink_en), .sample_ready(sample_ready), .sample_in(sample_in),
      .sample_qualifier(sample_qualifier), .downstream_ready(downstream_ready));

   //------------------------------------------------------------
   // Tasks
   //------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_of_test

   // Each access leaves one idle cycle so no strobe is assigned twice in a step
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      addr   <= a;
      wdata  <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
      @(posedge clk);
   endtask : wr

   task automatic rdchk(input string what, input logic [3:0] a, input logic [31:0] exp,
                        input logic qexp);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1;
      chk(what, rdata, exp);
      chk("read qualifier", {31'h0, rq}, {31'h0, qexp});
      @(posedge clk);
   endtask : rdchk

   function automatic logic [31:0] ext(input logic [WORD_W-1:0] w);
      return FMT_SIGNED ? DATA_W'($signed(w)) : DATA_W'(w);
   endfunction : ext

   //------------------------------------------------------------
   // Sequence
   //------------------------------------------------------------
   initial begin
      int n;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      chk("sample_ready", {31'h0, sample_ready}, 32'h1);
      @(posedge clk);
      // Hold the bus side and overfill the read queue from the sample side
      wr(REG_CTRL, 32'h1);
      src_total <= 8'ha;
      n = 0;
      while (n < 50) begin
         @(posedge clk);
         #1;
         if (sample_ready === 1'b0) break;
         n++;
      end
      if (n == 50) begin
         miscompares++;
         end_of_test();
      end
      @(posedge clk);
      rdchk("held read", REG_RD_DATA, 32'h0, 1'b0);
      rdchk("status full", REG_STATUS, 32'h0000_0816, 1'b0);
      wr(REG_CTRL, 32'h0);
      // Remaining two samples enter as the first pops free space
      for (int i = 0; i < 10; i++) begin
         rdchk("read word", REG_RD_DATA, ext(WORD_W'(16'h8a00 + i)), 1'b1);
      end
      rdchk("empty read", REG_RD_DATA, 32'h0, 1'b0);
      // Write queue under hold, downstream already willing
      wr(REG_CTRL, 32'h1);
      sink_en <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         wr(REG_WR_DATA, 32'h3c00 + i);
      end
      #1;
      chk("held valid", {31'h0, downstream_valid}, 32'h0);
      @(posedge clk);
      sink_en <= 1'b0;
      rdchk("status wr full", REG_STATUS, 32'h0008_0019, 1'b0);
      wr(REG_CTRL, 32'h0);
      sink_en <= 1'b1;
      #1;
      chk("early valid", {31'h0, downstream_valid}, 32'h0);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         #1;
         chk("valid", {31'h0, downstream_valid}, 32'h1);
         chk("word", {16'h0, downstream_word_out}, 32'h3c00 + i);
      end
      @(posedge clk);
      #1;
      chk("drained valid", {31'h0, downstream_valid}, 32'h0);
      @(posedge clk);
      rdchk("status idle", REG_STATUS, 32'h0000_0005, 1'b0);
      end_of_test();
   end
endmodule : tb_mmrwf_top
